// ===== pkg/mid_pkg.sv
// Purpose: Shared constants and types for the instruction decoder and sequencer
// Assumes: One clock, four clock periods to one instruction cycle
// Notes: Opcode patterns use ? for don't-care bits and feed casez matches
package mid_pkg;
  // ==========================================================
  // Register port map
  localparam logic [3:0] REG_CTRL = 4'h0; // Run and prescaler assignment
  localparam logic [3:0] REG_STAT = 4'h1; // Status bits, read only
  localparam logic [3:0] REG_WREG = 4'h2; // Working register, read only
  localparam logic [3:0] REG_IREG = 4'h3; // Low byte of current word, read only
  localparam int CTRL_RUN = 0; // Sequencer runs while set
  localparam int CTRL_PSA = 1; // 1: prescaler serves watchdog, 0: timer zero
  localparam int ST_C = 0; // Carry
  localparam int ST_DC = 1; // Digit carry
  localparam int ST_Z = 2; // Zero
  localparam int ST_PD = 3; // Power-down status
  localparam int ST_TO = 4; // Time-out status
  localparam int ST_SB = 5; // Standby active
  localparam logic [1:0] CTRL_RESET = 2'h0; // Stopped, prescaler to timer zero

  // ==========================================================
  // Word layout and special addresses
  localparam int IW = 14; // Instruction word width
  localparam int FW = 7; // File address width
  localparam int DBIT = 7; // Destination select bit
  localparam int BLO = 7; // Bit index low position
  localparam int BHI = 9; // Bit index high position
  localparam int KW = 11; // Jump target width
  localparam logic [6:0] TMR_ADDR = 7'h01; // Timer zero count address
  localparam logic [6:0] PORT_ADDR = 7'h06; // I/O port address
  localparam logic [13:0] NOP_WORD = 14'h0000; // Filler word for flushed cycles

  // ==========================================================
  // Opcode patterns
  localparam logic [13:0] P_NOP = 14'b00_0000_0??0_0000;
  localparam logic [13:0] P_RETURN = 14'b00_0000_0000_1000;
  localparam logic [13:0] P_RETFIE = 14'b00_0000_0000_1001;
  localparam logic [13:0] P_SLEEP = 14'b00_0000_0110_0011;
  localparam logic [13:0] P_WATCHDOG_CLEAR_INSTRUCTION = 14'b00_0000_0110_0100;
  localparam logic [13:0] P_MOVWF = 14'b00_0000_1???_????;
  localparam logic [13:0] P_CLRF = 14'b00_0001_1???_????;
  localparam logic [13:0] P_CLRW = 14'b00_0001_0???_????;
  localparam logic [13:0] P_BYTE = 14'b00_????_????_????;
  localparam logic [13:0] P_BIT = 14'b01_????_????_????;
  localparam logic [13:0] P_CALL = 14'b10_0???_????_????;
  localparam logic [13:0] P_UNCONDITIONAL_JUMP = 14'b10_1???_????_????;
  localparam logic [13:0] P_MOVLW = 14'b11_00??_????_????;
  localparam logic [13:0] P_RETURN_WITH_LITERAL = 14'b11_01??_????_????;
  localparam logic [13:0] P_OR_LITERAL_WITH_ACC = 14'b11_1000_????_????;
  localparam logic [13:0] P_ANDLW = 14'b11_1001_????_????;
  localparam logic [13:0] P_XORLW = 14'b11_1010_????_????;
  localparam logic [13:0] P_LITERAL_MINUS_ACC = 14'b11_110?_????_????;
  localparam logic [13:0] P_ADDLW = 14'b11_111?_????_????;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {MID_Q1 = 2'b00, MID_Q2 = 2'b01, MID_Q3 = 2'b11, MID_Q4 = 2'b10} mid_phase_e;
  typedef enum logic [5:0] {
    OP_NOP, OP_RETURN, OP_RETFIE, OP_SLEEP, OP_WATCHDOG_CLEAR_INSTRUCTION, OP_MOVWF, OP_CLRF, OP_CLRW,
    OP_SUBWF, OP_DECF, OP_OR_ACC_WITH_FILE, OP_ANDWF, OP_XOR_ACC_WITH_FILE, OP_ADDWF, OP_MOVF, OP_COMF,
    OP_INCF, OP_DECREMENT_SKIP_ZERO, OP_RRF, OP_RLF, OP_SWAPF, OP_INCREMENT_SKIP_ZERO, OP_BCF, OP_BSF,
    OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET, OP_CALL, OP_UNCONDITIONAL_JUMP, OP_MOVLW, OP_RETURN_WITH_LITERAL, OP_OR_LITERAL_WITH_ACC, OP_ANDLW,
    OP_XORLW, OP_LITERAL_MINUS_ACC, OP_ADDLW, OP_UNDEF
  } mid_op_e;
  typedef struct packed {logic c; logic dc; logic z;} mid_flags_s;
  typedef struct packed {logic pc_load; logic push; logic pop; logic ret_int;} mid_flow_s;
endpackage

// ===== rtl/mid_decoder.sv
// Purpose: Decode and sequence 14-bit words for an 8-bit core, four clocks per cycle
// Assumes: Program and data memory run on mclk; pins and wake/time-out come from outside
// Notes: Data memory must present file_rdata for file_addr_q by the fourth phase
// Summary of operation
// RULE1: Take 14-bit words: opcode plus operand fields
// RULE2: Destination bit zero writes W, one writes file
// RULE3: File operand is a 7-bit address
// RULE4: Three-bit index picks bit of file byte
// RULE5: Skip or branch adds one cycle as no-op
// RULE6: One instruction cycle is four clock periods
// RULE7: Call and jump carry 11-bit target, two cycles
// RULE8: File XOR honours destination, updates zero only
// RULE9: File inclusive OR updates zero only
// RULE10: Rotates go through carry, change carry only
// RULE11: Count-and-skip skips on zero, flags unchanged
// RULE12: Bit tests skip on clear or set
// RULE13: Literal minus W updates carry, digit carry, zero
// RULE14: Return with literal loads W, returns, two cycles
// RULE15: Literal inclusive OR updates zero only
// RULE16: Standby word enters standby, sets status bits
// RULE17: Port read-modify-write uses pin levels
// RULE18: Timer zero write clears prescaler when assigned
// RULE19: Don't-care bits accepted either way
// RULE20: Watchdog clear and standby clear watchdog, postscaler; code clears postscaler only when CTRL_PSA is set
// RULE21: Standby clears power-down, sets time-out; time-out clears it
// RULE22: Unlisted words run as one-cycle no-op
//
// Chosen here: strobed register access and the register offsets.
module mid_decoder (
  input wire logic mclk, // Core clock, 200 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic [13:0] instr_i, // Word from program memory
  input wire logic [7:0] file_rdata_i, // Data at file_addr_q
  input wire logic [7:0] pins_i, // Port pin levels, asynchronous
  input wire logic wdt_timeout_i, // Watchdog time-out level, asynchronous
  input wire logic wake_i, // Wake request level, asynchronous
  input wire logic [3:0] reg_addr_i, // Register port address
  input wire logic [7:0] reg_wdata_i, // Register write data
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  output logic [7:0] reg_rdata_q, // Read data, one cycle after strobe
  output logic fetch_q, // Pulse: next word wanted
  output logic [6:0] file_addr_q, // File address of current word
  output logic file_we_q, // Pulse: write file_wdata_q
  output logic [7:0] file_wdata_q, // Result for the file
  output logic [7:0] w_q, // Working register
  output mid_pkg::mid_flags_s flags_q, // Carry, digit carry, zero
  output mid_pkg::mid_flow_s flow_q, // Pulses toward program counter and stack
  output logic [10:0] target_q, // Jump or call target
  output logic timeout_status_bit_q, // Time-out status
  output logic powerdown_status_bit_q, // Power-down status
  output logic standby_q, // Standby level
  output logic prescaler_clr_q, // Pulse: clear shared prescaler
  output logic wdt_clr_q, // Pulse: clear watchdog counter
  output logic postscaler_clr_q // Pulse: clear watchdog postscaler
);
  // ==========================================================
  // Decode function
  // Don't-care bits are ? in the patterns, so both values match
  function automatic mid_pkg::mid_op_e mid_decode(input logic [13:0] iw);
    mid_pkg::mid_op_e op;
    op = mid_pkg::OP_UNDEF;
    casez (iw) // RULE19
      mid_pkg::P_NOP: op = mid_pkg::OP_NOP;
      mid_pkg::P_RETURN: op = mid_pkg::OP_RETURN;
      mid_pkg::P_RETFIE: op = mid_pkg::OP_RETFIE;
      mid_pkg::P_SLEEP: op = mid_pkg::OP_SLEEP; // RULE16
      mid_pkg::P_WATCHDOG_CLEAR_INSTRUCTION: op = mid_pkg::OP_WATCHDOG_CLEAR_INSTRUCTION;
      mid_pkg::P_MOVWF: op = mid_pkg::OP_MOVWF;
      mid_pkg::P_CLRF: op = mid_pkg::OP_CLRF;
      mid_pkg::P_CLRW: op = mid_pkg::OP_CLRW;
      mid_pkg::P_BYTE:
      begin
        // Nibble 0000 and 0001 are caught above; leftovers stay undefined
        case (iw[11:8])
          4'h2: op = mid_pkg::OP_SUBWF;
          4'h3: op = mid_pkg::OP_DECF;
          4'h4: op = mid_pkg::OP_OR_ACC_WITH_FILE; // RULE9
          4'h5: op = mid_pkg::OP_ANDWF;
          4'h6: op = mid_pkg::OP_XOR_ACC_WITH_FILE; // RULE8
          4'h7: op = mid_pkg::OP_ADDWF;
          4'h8: op = mid_pkg::OP_MOVF;
          4'h9: op = mid_pkg::OP_COMF;
          4'hA: op = mid_pkg::OP_INCF;
          4'hB: op = mid_pkg::OP_DECREMENT_SKIP_ZERO; // RULE11
          4'hC: op = mid_pkg::OP_RRF; // RULE10
          4'hD: op = mid_pkg::OP_RLF; // RULE10
          4'hE: op = mid_pkg::OP_SWAPF;
          4'hF: op = mid_pkg::OP_INCREMENT_SKIP_ZERO; // RULE11
          default: op = mid_pkg::OP_UNDEF; // RULE22
        endcase
      end
      mid_pkg::P_BIT:
      begin
        case (iw[11:10])
          2'h0: op = mid_pkg::OP_BCF;
          2'h1: op = mid_pkg::OP_BSF;
          2'h2: op = mid_pkg::OP_TEST_SKIP_IF_CLEAR; // RULE12
          default: op = mid_pkg::OP_TEST_SKIP_IF_SET; // RULE12
        endcase
      end
      mid_pkg::P_CALL: op = mid_pkg::OP_CALL; // RULE7
      mid_pkg::P_UNCONDITIONAL_JUMP: op = mid_pkg::OP_UNCONDITIONAL_JUMP; // RULE7
      mid_pkg::P_MOVLW: op = mid_pkg::OP_MOVLW;
      mid_pkg::P_RETURN_WITH_LITERAL: op = mid_pkg::OP_RETURN_WITH_LITERAL; // RULE14
      mid_pkg::P_OR_LITERAL_WITH_ACC: op = mid_pkg::OP_OR_LITERAL_WITH_ACC; // RULE15
      mid_pkg::P_ANDLW: op = mid_pkg::OP_ANDLW;
      mid_pkg::P_XORLW: op = mid_pkg::OP_XORLW;
      mid_pkg::P_LITERAL_MINUS_ACC: op = mid_pkg::OP_LITERAL_MINUS_ACC; // RULE13
      mid_pkg::P_ADDLW: op = mid_pkg::OP_ADDLW;
      default: op = mid_pkg::OP_UNDEF; // RULE22
    endcase
    return op;
  endfunction

  // Adder returning {carry, digit carry, sum}; subtract passes ~b and cin=1
  function automatic logic [9:0] mid_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  // ==========================================================
  // State
  mid_pkg::mid_phase_e phase_q; // Phase within the instruction cycle
  logic [13:0] ir_q; // Word being executed
  logic flush_q; // Next cycle runs as no-op
  logic [1:0] ctrl_q; // Run and prescaler assignment
  logic [7:0] pins_m_q, pins_s_q; // Pin synchroniser stages
  logic [2:0] tmo_q; // Time-out sync, two stages plus edge history
  logic [1:0] wake_q; // Wake sync stages
  logic adv; // Sequencer moves this clock
  logic exec; // Execute strobe in the fourth phase
  mid_pkg::mid_op_e op; // Decoded current word

  assign adv = ctrl_q[mid_pkg::CTRL_RUN] && !standby_q;
  assign exec = adv && (phase_q == mid_pkg::MID_Q4);
  assign op = mid_decode(ir_q);

  // ==========================================================
  // Synchronisers
  // Logic reads the second stage; time-out also reads its third bit as edge history
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pins_m_q <= 8'h00;
      pins_s_q <= 8'h00;
      tmo_q <= 3'h0;
      wake_q <= 2'h0;
    end
    else
    begin
      pins_m_q <= pins_i;
      pins_s_q <= pins_m_q;
      tmo_q <= {tmo_q[1:0], wdt_timeout_i};
      wake_q <= {wake_q[0], wake_i};
    end
  end

  // ==========================================================
  // Phase divider: four clocks make one instruction cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      phase_q <= mid_pkg::MID_Q1;
    else if (adv)
    begin
      case (phase_q) // RULE6
        mid_pkg::MID_Q1: phase_q <= mid_pkg::MID_Q2;
        mid_pkg::MID_Q2: phase_q <= mid_pkg::MID_Q3;
        mid_pkg::MID_Q3: phase_q <= mid_pkg::MID_Q4;
        default: phase_q <= mid_pkg::MID_Q1;
      endcase
    end
  end

  // ==========================================================
  // Word latch in the first phase; a flushed cycle latches a no-op
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ir_q <= mid_pkg::NOP_WORD;
      file_addr_q <= 7'h00;
    end
    else if (adv && phase_q == mid_pkg::MID_Q1)
    begin
      ir_q <= flush_q ? mid_pkg::NOP_WORD : instr_i; // RULE1 RULE5
      file_addr_q <= instr_i[mid_pkg::FW-1:0]; // RULE3
    end
  end

  // ==========================================================
  // Execute datapath
  logic [7:0] src; // File operand, pins for the port
  logic [7:0] lit; // Eight-bit literal
  logic [2:0] bidx; // Bit index
  logic dsel; // Destination select
  logic [7:0] res; // Result byte
  logic [9:0] sum; // Adder output
  logic wr_w, wr_f, skip, sleep_op, watchdog_clear_instruction_op;
  mid_pkg::mid_flags_s fl_n; // Next flags
  mid_pkg::mid_flow_s flow_n; // Flow pulses

  // Port reads see pin levels so read-modify-write writes them back
  assign src = (file_addr_q == mid_pkg::PORT_ADDR) ? pins_s_q : file_rdata_i; // RULE17
  assign lit = ir_q[7:0];
  assign bidx = ir_q[mid_pkg::BHI:mid_pkg::BLO]; // RULE4
  assign dsel = ir_q[mid_pkg::DBIT];

  // One combinational pass per instruction
  always_comb
  begin
    res = 8'h00;
    sum = 10'h000;
    wr_w = 1'b0;
    wr_f = 1'b0;
    skip = 1'b0;
    sleep_op = 1'b0;
    watchdog_clear_instruction_op = 1'b0;
    fl_n = flags_q;
    flow_n = '0;
    case (op)
      mid_pkg::OP_MOVWF: begin res = w_q; wr_f = 1'b1; end
      mid_pkg::OP_CLRF, mid_pkg::OP_CLRW: begin res = 8'h00; fl_n.z = 1'b1; end
      mid_pkg::OP_SUBWF: begin sum = mid_add(src, ~w_q, 1'b1); res = sum[7:0]; end
      mid_pkg::OP_ADDWF: begin sum = mid_add(src, w_q, 1'b0); res = sum[7:0]; end
      mid_pkg::OP_DECF, mid_pkg::OP_DECREMENT_SKIP_ZERO: res = src - 8'h01;
      mid_pkg::OP_INCF, mid_pkg::OP_INCREMENT_SKIP_ZERO: res = src + 8'h01;
      mid_pkg::OP_OR_ACC_WITH_FILE: res = src | w_q; // RULE9
      mid_pkg::OP_ANDWF: res = src & w_q;
      mid_pkg::OP_XOR_ACC_WITH_FILE: res = src ^ w_q; // RULE8
      mid_pkg::OP_MOVF: res = src;
      mid_pkg::OP_COMF: res = ~src;
      mid_pkg::OP_RRF: begin res = {flags_q.c, src[7:1]}; fl_n.c = src[0]; end // RULE10
      mid_pkg::OP_RLF: begin res = {src[6:0], flags_q.c}; fl_n.c = src[7]; end // RULE10
      mid_pkg::OP_SWAPF: res = {src[3:0], src[7:4]};
      mid_pkg::OP_BCF: begin res = src & ~(8'h01 << bidx); wr_f = 1'b1; end // RULE4
      mid_pkg::OP_BSF: begin res = src | (8'h01 << bidx); wr_f = 1'b1; end
      mid_pkg::OP_TEST_SKIP_IF_CLEAR: skip = !src[bidx]; // RULE12
      mid_pkg::OP_TEST_SKIP_IF_SET: skip = src[bidx]; // RULE12
      mid_pkg::OP_CALL: begin flow_n.pc_load = 1'b1; flow_n.push = 1'b1; end // RULE7
      mid_pkg::OP_UNCONDITIONAL_JUMP: flow_n.pc_load = 1'b1; // RULE7
      mid_pkg::OP_RETURN: flow_n.pop = 1'b1;
      mid_pkg::OP_RETFIE: begin flow_n.pop = 1'b1; flow_n.ret_int = 1'b1; end
      mid_pkg::OP_RETURN_WITH_LITERAL: begin res = lit; wr_w = 1'b1; flow_n.pop = 1'b1; end // RULE14
      mid_pkg::OP_MOVLW: begin res = lit; wr_w = 1'b1; end
      mid_pkg::OP_OR_LITERAL_WITH_ACC: begin res = lit | w_q; wr_w = 1'b1; end // RULE15
      mid_pkg::OP_ANDLW: begin res = lit & w_q; wr_w = 1'b1; end
      mid_pkg::OP_XORLW: begin res = lit ^ w_q; wr_w = 1'b1; end
      mid_pkg::OP_LITERAL_MINUS_ACC: begin sum = mid_add(lit, ~w_q, 1'b1); res = sum[7:0]; wr_w = 1'b1; end // RULE13
      mid_pkg::OP_ADDLW: begin sum = mid_add(lit, w_q, 1'b0); res = sum[7:0]; wr_w = 1'b1; end
      mid_pkg::OP_SLEEP: sleep_op = 1'b1; // RULE16
      mid_pkg::OP_WATCHDOG_CLEAR_INSTRUCTION: watchdog_clear_instruction_op = 1'b1;
      default: res = 8'h00; // RULE22
    endcase
    // Byte-oriented destination, counted skips, zero and arithmetic flags
    case (op)
      mid_pkg::OP_SUBWF, mid_pkg::OP_ADDWF, mid_pkg::OP_DECF, mid_pkg::OP_INCF, mid_pkg::OP_OR_ACC_WITH_FILE,
      mid_pkg::OP_ANDWF, mid_pkg::OP_XOR_ACC_WITH_FILE, mid_pkg::OP_MOVF, mid_pkg::OP_COMF, mid_pkg::OP_RRF,
      mid_pkg::OP_RLF, mid_pkg::OP_SWAPF, mid_pkg::OP_DECREMENT_SKIP_ZERO, mid_pkg::OP_INCREMENT_SKIP_ZERO:
      begin
        wr_f = dsel; // RULE2
        wr_w = !dsel; // RULE2
      end
      mid_pkg::OP_CLRF: wr_f = 1'b1;
      mid_pkg::OP_CLRW: wr_w = 1'b1;
      default: skip = skip;
    endcase
    case (op)
      mid_pkg::OP_DECREMENT_SKIP_ZERO, mid_pkg::OP_INCREMENT_SKIP_ZERO: skip = (res == 8'h00); // RULE11
      mid_pkg::OP_SUBWF, mid_pkg::OP_ADDWF, mid_pkg::OP_LITERAL_MINUS_ACC, mid_pkg::OP_ADDLW:
      begin
        fl_n.c = sum[9]; // RULE13
        fl_n.dc = sum[8];
        fl_n.z = (res == 8'h00);
      end
      mid_pkg::OP_DECF, mid_pkg::OP_INCF, mid_pkg::OP_OR_ACC_WITH_FILE, mid_pkg::OP_ANDWF, mid_pkg::OP_XOR_ACC_WITH_FILE,
      mid_pkg::OP_MOVF, mid_pkg::OP_COMF, mid_pkg::OP_OR_LITERAL_WITH_ACC, mid_pkg::OP_ANDLW, mid_pkg::OP_XORLW:
        fl_n.z = (res == 8'h00); // RULE8 RULE9 RULE15
      default: fl_n.z = fl_n.z;
    endcase
  end

  // ==========================================================
  // Result registers and one-cycle pulses
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      file_we_q <= 1'b0;
      file_wdata_q <= 8'h00;
      w_q <= 8'h00;
      flags_q <= '0;
      flow_q <= '0;
      target_q <= 11'h000;
      flush_q <= 1'b0;
      fetch_q <= 1'b0;
      prescaler_clr_q <= 1'b0;
      wdt_clr_q <= 1'b0;
      postscaler_clr_q <= 1'b0;
    end
    else
    begin
      file_we_q <= exec && wr_f;
      fetch_q <= exec;
      flow_q <= exec ? flow_n : '0;
      // Writes to timer zero restart the prescaler only when it serves timer zero
      prescaler_clr_q <= exec && wr_f && file_addr_q == mid_pkg::TMR_ADDR
                         && !ctrl_q[mid_pkg::CTRL_PSA]; // RULE18
      wdt_clr_q <= exec && (sleep_op || watchdog_clear_instruction_op); // RULE20
      postscaler_clr_q <= exec && (sleep_op || watchdog_clear_instruction_op) && ctrl_q[mid_pkg::CTRL_PSA]; // RULE20
      if (exec)
      begin
        file_wdata_q <= res;
        if (wr_w)
          w_q <= res; // RULE2
        flags_q <= fl_n;
        target_q <= ir_q[mid_pkg::KW-1:0]; // RULE7
        // A taken skip or any program counter change costs a no-op cycle
        flush_q <= skip || flow_n.pc_load || flow_n.pop; // RULE5
      end
      else if (adv && phase_q == mid_pkg::MID_Q1)
        flush_q <= 1'b0;
    end
  end

  // ==========================================================
  // Standby and status bits
  // Standby setting wins over a same-cycle time-out clear
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      standby_q <= 1'b0;
      timeout_status_bit_q <= 1'b1;
      powerdown_status_bit_q <= 1'b1;
    end
    else
    begin
      if (exec && sleep_op)
        standby_q <= 1'b1; // RULE16
      else if (wake_q[1] || (tmo_q[1] && !tmo_q[2]))
        standby_q <= 1'b0;
      if (exec && sleep_op)
      begin
        timeout_status_bit_q <= 1'b1; // RULE21
        powerdown_status_bit_q <= 1'b0; // RULE21
      end
      else if (exec && watchdog_clear_instruction_op)
      begin
        timeout_status_bit_q <= 1'b1;
        powerdown_status_bit_q <= 1'b1;
      end
      else if (tmo_q[1] && !tmo_q[2])
        timeout_status_bit_q <= 1'b0; // RULE21
    end
  end

  // ==========================================================
  // Register port; unmapped reads return zero, unmapped writes are dropped
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_q <= mid_pkg::CTRL_RESET;
    else if (reg_wr_i && reg_addr_i == mid_pkg::REG_CTRL)
      ctrl_q <= reg_wdata_i[1:0];
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata_q <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        mid_pkg::REG_CTRL: reg_rdata_q <= {6'h00, ctrl_q};
        mid_pkg::REG_STAT: reg_rdata_q <= {2'h0, standby_q, timeout_status_bit_q,
                                           powerdown_status_bit_q, flags_q.z, flags_q.dc, flags_q.c};
        mid_pkg::REG_WREG: reg_rdata_q <= w_q;
        mid_pkg::REG_IREG: reg_rdata_q <= ir_q[7:0];
        default: reg_rdata_q <= 8'h00;
      endcase
    end
    else
      reg_rdata_q <= 8'h00;
  end

  // ==========================================================
  // Checks
  sequence s_flush_latch;
    flush_q && adv && phase_q == mid_pkg::MID_Q1;
  endsequence
  sequence s_exec_of(mid_pkg::mid_op_e o);
    exec && op == o;
  endsequence

  AST_PHASE_STEP: assert property (@(posedge mclk) disable iff (!rst_b) // RULE6
    adv && phase_q == mid_pkg::MID_Q1 |=> phase_q == mid_pkg::MID_Q2)
    else $error("phase did not advance");
  AST_FETCH_GAP: assert property (@(posedge mclk) disable iff (!rst_b) // RULE6
    fetch_q |=> !fetch_q [*3])
    else $error("fetch pulses closer than four clocks");
  AST_DEST_W: assert property (@(posedge mclk) disable iff (!rst_b) // RULE2
    s_exec_of(mid_pkg::OP_OR_ACC_WITH_FILE) ##0 !dsel |=> !file_we_q && w_q == $past(src | w_q))
    else $error("d=0 result not in W");
  AST_FLUSH_NOP: assert property (@(posedge mclk) disable iff (!rst_b) // RULE5
    s_flush_latch |=> ir_q == mid_pkg::NOP_WORD)
    else $error("second cycle not a no-op");
  AST_JUMP_TWO: assert property (@(posedge mclk) disable iff (!rst_b) // RULE7
    s_exec_of(mid_pkg::OP_UNCONDITIONAL_JUMP) |=> flow_q.pc_load && flush_q && target_q == $past(ir_q[10:0]))
    else $error("jump not loaded");
  AST_SLEEP_BITS: assert property (@(posedge mclk) disable iff (!rst_b) // RULE21
    s_exec_of(mid_pkg::OP_SLEEP) |=> standby_q && timeout_status_bit_q && !powerdown_status_bit_q && wdt_clr_q)
    else $error("standby status wrong");
  AST_TMR_CLR: assert property (@(posedge mclk) disable iff (!rst_b) // RULE18
    exec && wr_f && file_addr_q == mid_pkg::TMR_ADDR && !ctrl_q[mid_pkg::CTRL_PSA] |=> prescaler_clr_q)
    else $error("prescaler not cleared");
  AST_ROT_FLAGS: assert property (@(posedge mclk) disable iff (!rst_b) // RULE10
    s_exec_of(mid_pkg::OP_RLF) |=> flags_q.z == $past(flags_q.z) && flags_q.c == $past(src[7]))
    else $error("rotate flags wrong");
  AST_UNDEF_NOP: assert property (@(posedge mclk) disable iff (!rst_b) // RULE22
    s_exec_of(mid_pkg::OP_UNDEF) |=> !file_we_q && !flush_q && $stable(w_q) && $stable(flags_q))
    else $error("undefined word had an effect");
endmodule

// ===== tb/mid_decoder_bench.sv
// Purpose: Run a short program through the decoder and check results
// Assumes: Memory model feeds words; register port reads status
// Notes: Filler word first; skips are seen through the final W
module mid_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0; // Core clock
  logic rst_b = 1'b0; // Reset, active low
  logic [7:0] pins_i = 8'hA5; // Pin levels
  logic wdt_timeout_i = 1'b0; // Time-out level
  logic [3:0] reg_addr_i = 4'h0; // Register address
  logic [7:0] reg_wdata_i = 8'h00; // Write data
  logic reg_wr_i = 1'b0; // Write strobe
  logic reg_rd_i = 1'b0; // Read strobe
  wire logic [13:0] instr_i; // Word to decoder
  wire logic [7:0] file_rdata_i, reg_rdata_q, file_wdata_q, w_q; // Data paths
  wire logic [6:0] file_addr_q; // File address
  wire logic fetch_q, file_we_q, standby_q, prescaler_clr_q, wdt_clr_q, postscaler_clr_q; // Pulses
  int n_fail = 0, check_count = 0, n_pre = 0, n_wdt = 0, n_post = 0, cyc = 0; // Counters
  logic [13:0] prog [0:15] = '{14'h0000, 14'h335A, 14'h06A0, 14'h0420, 14'h0D21, 14'h0BA2, 14'h30FF,
    14'h1FA1, 14'h30EE, 14'h3800, 14'h3C01, 14'h0070, 14'h0081, 14'h0986, 14'h0064, 14'h0063}; // Program
  mid_decoder mid_decoder_i (.mclk, .rst_b, .instr_i, .file_rdata_i, .pins_i, .wdt_timeout_i,
    .wake_i(1'b0), .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_q, .fetch_q,
    .file_addr_q, .file_we_q, .file_wdata_q, .w_q, .flags_q(), .flow_q(), .target_q(),
    .timeout_status_bit_q(), .powerdown_status_bit_q(), .standby_q, .prescaler_clr_q,
    .wdt_clr_q, .postscaler_clr_q);
  mid_mem mid_mem_i (.mclk, .rst_b, .fetch_q, .file_addr_q, .file_we_q, .file_wdata_q,
    .instr_i, .file_rdata_i);
  // ====
  // Clock, pulse counting and hang limit
  always #2.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    n_pre += prescaler_clr_q;
    n_wdt += wdt_clr_q;
    n_post += postscaler_clr_q;
    if (cyc == 3000)
    begin
      n_fail++;
      complete_run();
    end
  end
  // ====
  // Compare, register access and verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk);
    reg_wr_i <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ====
  // Main sequence
  initial
  begin
    for (int i = 0; i < 32; i++)
      mid_mem_i.rom[i] = (i < 16) ? prog[i] : 14'h0000;
    // After wake: the fetch pulse of the standby word has stepped past the jump, so the return with a literal runs
    mid_mem_i.rom[16] = 14'h2805;
    mid_mem_i.rom[17] = 14'h3477;
    mid_mem_i.ram[7'h20] = 8'h0F;
    mid_mem_i.ram[7'h21] = 8'h80;
    mid_mem_i.ram[7'h22] = 8'h01;
    mid_mem_i.ram[7'h06] = 8'h00;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    rd(mid_pkg::REG_STAT, 8'h18);
    wr(mid_pkg::REG_STAT, 8'hFF);
    rd(4'hF, 8'h00);
    rd(mid_pkg::REG_STAT, 8'h18);
    wr(mid_pkg::REG_CTRL, 8'h01);
    while (standby_q !== 1'b1)
      @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk(w_q, 8'h01);
    rd(mid_pkg::REG_STAT, 8'h33);
    chk(mid_mem_i.ram[7'h20], 8'h55);
    chk(mid_mem_i.ram[7'h21], 8'h80);
    chk(mid_mem_i.ram[7'h22], 8'h00);
    chk(mid_mem_i.ram[7'h06], 8'h5A);
    chk(mid_mem_i.ram[7'h01], 8'h01);
    chk(8'(n_pre), 8'h01);
    chk(8'(n_wdt), 8'h02);
    chk(8'(n_post), 8'h00);
    wdt_timeout_i <= 1'b1;
    repeat (24) @(posedge mclk);
    rd(mid_pkg::REG_STAT, 8'h03);
    chk(w_q, 8'h77);
    complete_run();
  end
endmodule

// ===== tb/mid_mem.sv
// Purpose: Program and file memory beside the decoder
// Assumes: The word counter steps on each fetch pulse
// Notes: Branch targets are ignored; test programs run straight
module mid_mem (
  input wire logic mclk, // Core clock
  input wire logic rst_b, // Reset, active low
  input wire logic fetch_q, // Next word wanted
  input wire logic [6:0] file_addr_q, // File address
  input wire logic file_we_q, // File write pulse
  input wire logic [7:0] file_wdata_q, // File write data
  output logic [13:0] instr_i, // Program word
  output logic [7:0] file_rdata_i // File data
);
  logic [13:0] rom [0:31]; // Program, loaded by the bench
  logic [7:0] ram [0:127]; // File bytes, preset by the bench
  logic [4:0] pc_q; // Word counter
  // ====
  // Counter steps after each word, so the first word shows twice
  always @(posedge mclk or negedge rst_b)
    if (!rst_b)
      pc_q <= 5'h00;
    else if (fetch_q)
      pc_q <= pc_q + 5'h01;
  // Plain always: the bench presets these bytes too
  always @(posedge mclk)
    if (file_we_q)
      ram[file_addr_q] <= file_wdata_q;
  assign instr_i = rom[pc_q];
  assign file_rdata_i = ram[file_addr_q];
endmodule
